/* verilog/sdi_pkg.sv */
`default_nettype none

package sdi_pkg;
    localparam int NB = 4;
    localparam int AW = 13;
    localparam int AP_BIT = 10;
    localparam int MR_BL_LSB = 0;
    localparam int CNT_W = 6;
    localparam int CL_DEF = 2;
    localparam int BL_DEF = 4;
    localparam int CLK_NS = 4;
    localparam int T_RCD_NS = 20;
    localparam int T_RP_NS = 20;
    localparam int T_WR_NS = 15;
    localparam int T_XSR_NS = 75;
    // Least times, so each rounds up to whole clock cycles.
    localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int XSR_CYC = (T_XSR_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        BK_IDLE = 4'h0,
        BK_ACTV = 4'h1,
        BK_ACTIVE = 4'h2,
        BK_RD = 4'h3,
        BK_WR = 4'h4,
        BK_RD_AP = 4'h5,
        BK_WR_AP = 4'h6,
        BK_PRE = 4'h7
    } sdi_bank_st_t;

    typedef enum logic [2:0] {
        SDI_NOP = 3'h0,
        SDI_ACT = 3'h1,
        SDI_RD = 3'h2,
        SDI_WR = 3'h3,
        SDI_PRE = 3'h4,
        SDI_BST = 3'h5,
        SDI_REF = 3'h6,
        SDI_LMR = 3'h7
    } sdi_op_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [AW-1:0] addr;
    } sdi_cmd_t;
endpackage

`default_nettype wire

/* verilog/sdi_bank_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module sdi_fifo #(parameter int W = 8, parameter int D = 4) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [PW-1:0] rp_q, rp_d, wp_q, wp_d;
    logic [PW:0] n_q, n_d;
    logic push, pop;

    if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
        $error("FIFO depth must be a power of two of at least two.");
    end

    assign in_ready = n_q != (PW + 1)'(D);
    assign out_valid = n_q != '0;
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        rp_d = rp_q + PW'(pop);
        wp_d = wp_q + PW'(push);
        n_d = n_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rp_q <= '0;
            wp_q <= '0;
            n_q <= '0;
        end else begin
            rp_q <= rp_d;
            wp_q <= wp_d;
            n_q <= n_d;
        end
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule // sdi_fifo

// Overview of operation
// - Chip select high: inhibit, operations continue
// - NOP leaves every bank untouched
// - Idle bank n never restricts bank m
// - Burst terminate hits only the running burst
// - Auto precharge choice never changes permissions
// - Cut auto-precharge burst precharges by itself
// - Precharge to m keeps n's burst
// - Read cuts read, data one latency later
// - Write cuts read at once; DQM lead
// - Read ends write; last data before
// - Write ends write; last data before
// - Read cuts AP read, precharge starts now
// - Write cuts AP read, precharge starts now
// - Read cuts AP write, recovery then precharge
// - Write cuts AP write, recovery then precharge
// - Commands only with clock enable held high
// - AP state lasts until precharge time met
// - Decode commands from strobe levels
module sdi_bank_ctrl #(
    parameter int CL = sdi_pkg::CL_DEF,
    parameter int DW = 16,
    parameter int MCW = 4,
    parameter int FD = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command pins
    input wire logic cke,
    input wire sdi_pkg::sdi_cmd_t cmd,
    // Data pins
    input wire logic [DW-1:0] dq_i,
    input wire logic dqm,
    output logic [DW-1:0] dq_o,
    output logic dq_oe,
    // Status
    output logic wbuf_ready,
    output logic illegal_cmd,
    output logic self_refresh,
    output var sdi_pkg::sdi_bank_st_t [sdi_pkg::NB-1:0] bank_state
);
    import sdi_pkg::*;
    localparam int CLP = CL;
    localparam int MA = 2 + MCW;

    if (CL < 1 || CL > 3 || MCW < 1 || MCW > AP_BIT || FD < 2 ||
        WR_CYC + RP_CYC >= 2 ** CNT_W || XSR_CYC >= 2 ** CNT_W)
    begin : g_chk
        $error("Unsupported latency, column width or timing.");
    end

    logic cke_q, srf_q, srf_d, ill_q;
    logic [CNT_W-1:0] xsr_q, xsr_d;
    sdi_op_t op;
    logic ap, cmd_ok, legal, all_idle, new_rd, new_wr;
    logic [1:0] bk;
    sdi_bank_st_t st_q [NB];
    sdi_bank_st_t st_d [NB];
    sdi_bank_st_t eff [NB];
    logic [CNT_W-1:0] cnt_q [NB];
    logic [CNT_W-1:0] cnt_d [NB];
    logic [NB-1:0] apg_q, apg_d, pre_ok;
    logic bur_on_q, bur_on_d, bur_rd_q, bur_rd_d;
    logic [1:0] bur_bk_q, bur_bk_d;
    logic [MCW-1:0] bur_col_q, bur_col_d;
    logic [3:0] bur_left_q, bur_left_d, bl_q, bl_d;
    logic iss, iss_rd, end_ev;
    logic [MA-1:0] iss_addr;
    logic [CL-1:0] pv_q, pv_d;
    logic [DW-1:0] pd_q [CL];
    logic [DW-1:0] pd_d [CL];
    logic [DW-1:0] dmem [2 ** MA];
    logic fin_v, fo_v, fo_rdy;
    logic [MA+DW-1:0] fo_data;
    logic [1:0] since_wr_q, since_wr_d;

    assign ap = cmd.addr[AP_BIT];
    assign bk = cmd.ba;
    assign new_rd = op == SDI_RD && legal;
    assign new_wr = op == SDI_WR && legal;
    // Pins are launched on this same clock, so they are sampled directly.
    assign dq_o = pd_q[CL-1];
    assign dq_oe = pv_q[CL-1];
    assign illegal_cmd = ill_q;
    assign self_refresh = srf_q;

    always_comb begin
        cmd_ok = cke_q && cke && !srf_q && xsr_q == '0;
        op = SDI_NOP;
        if (cmd_ok && !cmd.cs_n) begin
            case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
                3'h3: op = SDI_ACT;
                3'h5: op = SDI_RD;
                3'h4: op = SDI_WR;
                3'h2: op = SDI_PRE;
                3'h6: op = SDI_BST;
                3'h1: op = SDI_REF;
                3'h0: op = SDI_LMR;
                default: op = SDI_NOP;
            endcase
        end
    end

    // A bank whose timer ran out is treated as having moved on.
    always_comb begin
        all_idle = 1'b1;
        for (int b = 0; b < NB; b++) begin
            eff[b] = st_q[b];
            if (cnt_q[b] == '0 && st_q[b] == BK_ACTV) begin
                eff[b] = BK_ACTIVE;
            end
            if (cnt_q[b] == '0 && (st_q[b] == BK_PRE || apg_q[b])) begin
                eff[b] = BK_IDLE;
            end
            pre_ok[b] = eff[b] inside {BK_IDLE, BK_ACTIVE, BK_RD, BK_WR};
            if (eff[b] != BK_IDLE) begin
                all_idle = 1'b0;
            end
            bank_state[b] = st_q[b];
        end
    end

    // Activate, read, write and single-bank precharge look at the target bank only; precharge-all, refresh and mode load check every bank.
    always_comb begin
        case (op)
            SDI_ACT: legal = eff[bk] == BK_IDLE;
            SDI_RD, SDI_WR: legal = pre_ok[bk] && eff[bk] != BK_IDLE;
            SDI_PRE: legal = ap ? &pre_ok : pre_ok[bk];
            SDI_BST: legal = bur_on_q &&
                (st_q[bur_bk_q] inside {BK_RD, BK_WR});
            SDI_REF, SDI_LMR: legal = all_idle;
            default: legal = 1'b1;
        endcase
    end

    always_comb begin
        bur_on_d = bur_on_q;
        bur_rd_d = bur_rd_q;
        bur_bk_d = bur_bk_q;
        bur_col_d = bur_col_q;
        bur_left_d = bur_left_q;
        bl_d = bl_q;
        iss = 1'b0;
        iss_rd = bur_rd_q;
        iss_addr = {bur_bk_q, bur_col_q};
        end_ev = 1'b0;
        if (op == SDI_LMR && legal) begin
            bl_d = 4'h1 << cmd.addr[MR_BL_LSB +: 2];
        end
        if (new_rd || new_wr) begin
            end_ev = bur_on_q;
            iss = 1'b1;
            iss_rd = new_rd;
            iss_addr = {bk, cmd.addr[MCW-1:0]};
            bur_rd_d = new_rd;
            bur_bk_d = bk;
            bur_col_d = cmd.addr[MCW-1:0] + MCW'(1);
            bur_left_d = bl_q - 4'h1;
            bur_on_d = bl_q != 4'h1;
        end else if (bur_on_q && (op == SDI_BST || (op == SDI_PRE &&
                     legal && (ap || bk == bur_bk_q)))) begin
            bur_on_d = 1'b0;
            end_ev = 1'b1;
        end else if (bur_on_q) begin
            iss = 1'b1;
            bur_col_d = bur_col_q + MCW'(1);
            bur_left_d = bur_left_q - 4'h1;
            bur_on_d = bur_left_q != 4'h1;
            end_ev = bur_left_q == 4'h1;
        end
    end

    // Write data is taken at the edge it arrives; the edge of an
    // interrupting command belongs to the new burst.
    assign fin_v = iss && !iss_rd && !dqm;
    // Single memory port: reads win, so queued writes wait in the FIFO.
    // A read of a word still queued returns the older contents.
    assign fo_rdy = !(iss && iss_rd);

    always_comb begin
        for (int i = 0; i < CL; i++) begin
            if (i == 0) begin
                pv_d[i] = iss && iss_rd;
                pd_d[i] = dmem[iss_addr];
            end else begin
                pv_d[i] = pv_q[i-1];
                pd_d[i] = pd_q[i-1];
            end
        end
        if (new_wr) begin
            pv_d = '0;
        end
        since_wr_d = new_wr ? 2'h0 :
            (since_wr_q == 2'h3 ? 2'h3 : since_wr_q + 2'h1);
    end

    always_comb begin
        for (int b = 0; b < NB; b++) begin
            st_d[b] = eff[b];
            cnt_d[b] = cnt_q[b] == '0 ? '0 : cnt_q[b] - CNT_W'(1);
            apg_d[b] = apg_q[b] && eff[b] != BK_IDLE;
            if (end_ev && bur_bk_q == 2'(b)) begin
                if (st_q[b] inside {BK_RD, BK_WR}) begin
                    st_d[b] = BK_ACTIVE;
                end else begin
                    apg_d[b] = 1'b1;
                    cnt_d[b] = st_q[b] == BK_RD_AP ? CNT_W'(RP_CYC - 1) :
                        CNT_W'(WR_CYC + RP_CYC - 1);
                end
            end
            if (legal && bk == 2'(b)) begin
                case (op)
                    SDI_ACT: begin
                        st_d[b] = BK_ACTV;
                        cnt_d[b] = CNT_W'(RCD_CYC - 1);
                    end
                    SDI_RD, SDI_WR: begin
                        apg_d[b] = ap && bl_q == 4'h1;
                        cnt_d[b] = op == SDI_RD ? CNT_W'(RP_CYC - 1) :
                            CNT_W'(WR_CYC + RP_CYC - 1);
                        if (ap) begin
                            st_d[b] = op == SDI_RD ? BK_RD_AP : BK_WR_AP;
                        end else if (bl_q == 4'h1) begin
                            st_d[b] = BK_ACTIVE;
                        end else begin
                            st_d[b] = op == SDI_RD ? BK_RD : BK_WR;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (legal && op == SDI_PRE && (ap || bk == 2'(b)) &&
                eff[b] != BK_IDLE) begin
                st_d[b] = BK_PRE;
                cnt_d[b] = CNT_W'(RP_CYC - 1);
                apg_d[b] = 1'b0;
            end
        end
    end

    // Clock suspend and power-down only mask commands here; bursts run on.
    always_comb begin
        srf_d = srf_q;
        xsr_d = xsr_q == '0 ? '0 : xsr_q - CNT_W'(1);
        if (!srf_q && cke_q && !cke && !cmd.cs_n && all_idle &&
            {cmd.ras_n, cmd.cas_n, cmd.we_n} == 3'h1) begin
            srf_d = 1'b1;
        end
        if (srf_q && cke) begin
            srf_d = 1'b0;
            xsr_d = CNT_W'(XSR_CYC);
        end
    end

    sdi_fifo #(.W(MA + DW), .D(FD)) u_wbuf (
        .clk(clk),
        .rst(rst),
        .in_valid(fin_v),
        .in_ready(wbuf_ready),
        .in_data({iss_addr, dq_i}),
        .out_valid(fo_v),
        .out_ready(fo_rdy),
        .out_data(fo_data)
    );

    always_ff @(posedge clk) begin
        if (fo_v && fo_rdy) begin
            dmem[fo_data[MA+DW-1:DW]] <= fo_data[DW-1:0];
        end
        pd_q <= pd_d;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cke_q <= 1'b0;
            srf_q <= 1'b0;
            xsr_q <= '0;
            ill_q <= 1'b0;
            apg_q <= '0;
            bur_on_q <= 1'b0;
            bur_rd_q <= 1'b0;
            bur_bk_q <= 2'h0;
            bur_col_q <= '0;
            bur_left_q <= 4'h0;
            bl_q <= 4'(BL_DEF);
            pv_q <= '0;
            since_wr_q <= 2'h3;
            for (int b = 0; b < NB; b++) begin
                st_q[b] <= BK_IDLE;
                cnt_q[b] <= '0;
            end
        end else begin
            cke_q <= cke;
            srf_q <= srf_d;
            xsr_q <= xsr_d;
            ill_q <= op != SDI_NOP && !legal;
            apg_q <= apg_d;
            bur_on_q <= bur_on_d;
            bur_rd_q <= bur_rd_d;
            bur_bk_q <= bur_bk_d;
            bur_col_q <= bur_col_d;
            bur_left_q <= bur_left_d;
            bl_q <= bl_d;
            pv_q <= pv_d;
            since_wr_q <= since_wr_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    property p_inhibit;
        @(posedge clk) disable iff (rst)
        cmd.cs_n && st_q[0] == BK_ACTIVE |=> st_q[0] == BK_ACTIVE;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("Inhibited edge changed an active bank.");

    property p_nop;
        @(posedge clk) disable iff (rst)
        op == SDI_NOP && bur_on_q && bur_left_q > 4'h1
        |=> bur_on_q && $stable(bur_bk_q);
    endproperty
    a_nop: assert property (p_nop)
        else $error("No-operation disturbed a running burst.");

    property p_bst;
        @(posedge clk) disable iff (rst)
        op == SDI_BST && legal |=> !bur_on_q &&
            !(st_q[0] inside {BK_RD, BK_WR});
    endproperty
    a_bst: assert property (p_bst)
        else $error("Burst terminate left a burst running.");

    property p_ap_cut;
        @(posedge clk) disable iff (rst)
        bur_on_q && bur_bk_q == 2'h0 && st_q[0] == BK_RD_AP &&
        (new_rd || new_wr) && bk != 2'h0
        |=> apg_q[0] && st_q[0] == BK_RD_AP;
    endproperty
    a_ap_cut: assert property (p_ap_cut)
        else $error("Cut auto-precharge bank did not precharge.");

    property p_pre_m;
        @(posedge clk) disable iff (rst)
        bur_on_q && bur_left_q > 4'h1 && op == SDI_PRE && legal && !ap &&
        bk != bur_bk_q |=> bur_on_q && $stable(bur_bk_q);
    endproperty
    a_pre_m: assert property (p_pre_m)
        else $error("Precharge to another bank stopped the burst.");

    property p_rd_lat;
        @(posedge clk) disable iff (rst)
        iss && iss_rd |-> ##CLP (dq_oe || since_wr_q < 2'(CLP));
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("Read data missing one latency after issue.");

    property p_wr_cut;
        @(posedge clk) disable iff (rst)
        new_wr |=> !dq_oe;
    endproperty
    a_wr_cut: assert property (p_wr_cut)
        else $error("Read output still driven after write.");

    property p_wr_last;
        @(posedge clk) disable iff (rst)
        bur_on_q && !bur_rd_q && new_rd |-> !fin_v;
    endproperty
    a_wr_last: assert property (p_wr_last)
        else $error("Write data taken on the interrupting read edge.");

    property p_rd_ap_pre;
        @(posedge clk) disable iff (rst)
        bur_on_q && bur_bk_q == 2'h0 && st_q[0] == BK_RD_AP && new_rd &&
        bk != 2'h0 |=> cnt_q[0] == CNT_W'(RP_CYC - 1);
    endproperty
    a_rd_ap_pre: assert property (p_rd_ap_pre)
        else $error("Precharge did not start at the cutting read.");

    property p_wr_ap_rd;
        @(posedge clk) disable iff (rst)
        bur_on_q && bur_bk_q == 2'h0 && st_q[0] == BK_WR_AP && new_rd &&
        bk != 2'h0 |=> cnt_q[0] == CNT_W'(WR_CYC + RP_CYC - 1);
    endproperty
    a_wr_ap_rd: assert property (p_wr_ap_rd)
        else $error("Write recovery not counted from the read.");

    property p_wr_ap_wr;
        @(posedge clk) disable iff (rst)
        bur_on_q && bur_bk_q == 2'h0 && st_q[0] == BK_WR_AP && new_wr &&
        bk != 2'h0 |=> apg_q[0] ##1 cnt_q[0] == CNT_W'(WR_CYC + RP_CYC - 2);
    endproperty
    a_wr_ap_wr: assert property (p_wr_ap_wr)
        else $error("Write recovery not counted from the write.");

    property p_ap_idle;
        @(posedge clk) disable iff (rst)
        apg_q[0] && cnt_q[0] == '0 && !(legal && bk == 2'h0 &&
        op == SDI_ACT) |=> st_q[0] == BK_IDLE;
    endproperty
    a_ap_idle: assert property (p_ap_idle)
        else $error("Bank not idle once precharge time met.");
endmodule // sdi_bank_ctrl

`default_nettype wire

/* test/sdi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Stands in for the memory controller; every pin changes at a falling edge.
module sdi_host_model (
    // Clock
    input wire logic clk,
    // Command and data pins
    output logic cke,
    output sdi_pkg::sdi_cmd_t cmd,
    output logic [15:0] dq_i,
    output logic dqm
);
    import sdi_pkg::*;

    initial begin
        cke = 1'b1;
        cmd = '1;
        dq_i = 16'h0000;
        dqm = 1'b0;
    end

    // One command for one edge; nothing is checked here, and some callers send illegal commands on purpose.
    task automatic put(input sdi_op_t op, input logic [1:0] ba,
                       input logic [AW-1:0] a, input logic [15:0] d,
                       input logic m, input logic inh);
        logic [2:0] e;
        case (op)
            SDI_ACT: e = 3'h3;
            SDI_RD: e = 3'h5;
            SDI_WR: e = 3'h4;
            SDI_PRE: e = 3'h2;
            SDI_BST: e = 3'h6;
            SDI_REF: e = 3'h1;
            SDI_LMR: e = 3'h0;
            default: e = 3'h7;
        endcase
        cmd = {inh, e, ba, a};
        dq_i = d;
        dqm = m;
        @(negedge clk);
    endtask

    // A released data bus keeps changing, so stale words never look valid.
    task automatic nop(input int k);
        cmd = {1'b0, 3'h7, 2'h0, 13'h0000};
        dqm = 1'b0;
        repeat (k) begin
            dq_i = ~dq_i;
            @(negedge clk);
        end
    endtask
endmodule // sdi_host_model

`default_nettype wire

/* test/test_sdi_bank_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) chk_v(32'(g), 32'(e), `__LINE__)

module test_sdi_bank_ctrl;
    import sdi_pkg::*;
    localparam int RDL = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cke;
    sdi_cmd_t cmd;
    logic [15:0] dq_i;
    logic dqm;
    logic [15:0] dq_o;
    logic dq_oe;
    logic wbuf_ready;
    logic illegal_cmd;
    logic self_refresh;
    sdi_bank_st_t [NB-1:0] bank_state;
    logic [15:0] exp_q[$];
    int n_ill = 0;
    int n_mismatch = 0;
    int tests_run = 0;

    always #2 clk = ~clk;

    always @(posedge clk) if (illegal_cmd === 1'b1) n_ill <= n_ill + 1;

    sdi_host_model m (.clk(clk), .cke(cke), .cmd(cmd), .dq_i(dq_i),
                      .dqm(dqm));

    sdi_bank_ctrl #(.CL(RDL)) uut (.clk(clk), .rst(rst), .cke(cke),
        .cmd(cmd), .dq_i(dq_i), .dqm(dqm), .dq_o(dq_o), .dq_oe(dq_oe),
        .wbuf_ready(wbuf_ready), .illegal_cmd(illegal_cmd),
        .self_refresh(self_refresh), .bank_state(bank_state));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_v(input logic [31:0] g, e, input int ln);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t line %0d got %h exp %h", $time, ln, g, e);
        end
    endtask

    task automatic wr_burst(input logic [1:0] ba, input logic [12:0] c,
                            input logic [15:0] d, input int n);
        m.put(SDI_WR, ba, c, d, 1'b0, 1'b0);
        for (int i = 1; i < n; i++) m.put(SDI_NOP, 2'h0, 13'h0, d + i, 0, 0);
    endtask

    task automatic rd_stream(input int lat);
        int k;
        m.nop(0);
        k = 0;
        while (dq_oe !== 1'b1 && k < 8) begin
            @(negedge clk);
            k++;
        end
        `CHK(k, lat);
        if (k == 8) tally_and_finish();
        foreach (exp_q[i]) begin
            `CHK(dq_o, exp_q[i]);
            @(negedge clk);
        end
        `CHK(dq_oe, 1'b0);
    endtask

    task automatic t_act();
        int n0;
        n0 = n_ill;
        m.put(SDI_LMR, 2'h0, 13'h0002, 0, 0, 0);
        m.nop(3);
        m.put(SDI_ACT, 2'h2, 13'h0, 0, 0, 1'b1);
        m.put(SDI_ACT, 2'h0, 13'h0, 0, 0, 0);
        m.put(SDI_ACT, 2'h1, 13'h0, 0, 0, 0);
        `CHK(bank_state[0], BK_ACTV);
        `CHK(bank_state[1], BK_ACTV);
        m.cke = 1'b0;
        m.put(SDI_ACT, 2'h3, 13'h0, 0, 0, 0);
        m.cke = 1'b1;
        m.nop(4);
        `CHK(bank_state[2], BK_IDLE);
        `CHK(bank_state[3], BK_IDLE);
        `CHK(bank_state[1], BK_ACTIVE);
        `CHK(n_ill, n0);
    endtask

    // Bank 0 bursts are cut by bank 1 and back; data read back later.
    task automatic t_write();
        wr_burst(1, 4, 16'hE000, 4);
        wr_burst(0, 0, 16'hA000, 4);
        m.nop(6);
        wr_burst(0, 0, 16'hB000, 2);
        wr_burst(1, 0, 16'hC000, 4);
        m.nop(6);
        wr_burst(1, 4, 16'hF000, 2);
        m.put(SDI_RD, 2'h0, 13'h0, 16'h7777, 0, 0);
        exp_q = '{16'hB000, 16'hB001, 16'hA002, 16'hA003};
        rd_stream(RDL - 1);
        m.nop(4);
        m.put(SDI_RD, 2'h0, 13'h0, 0, 0, 0);
        m.put(SDI_RD, 2'h1, 13'h4, 0, 0, 0);
        exp_q = '{16'hB000, 16'hF000, 16'hF001, 16'hE002, 16'hE003};
        rd_stream(RDL - 2);
    endtask

    task automatic t_wr_cuts_rd();
        logic seen;
        seen = 1'b0;
        m.put(SDI_RD, 2'h0, 13'h0, 0, 1'b1, 0);
        m.put(SDI_WR, 2'h1, 13'h8, 16'hD000, 0, 0);
        m.nop(0);
        repeat (5) begin
            seen = seen | dq_oe;
            @(negedge clk);
        end
        `CHK(seen, 1'b0);
    endtask

    task automatic t_pre_keeps();
        m.put(SDI_RD, 2'h0, 13'h0, 0, 0, 0);
        m.put(SDI_PRE, 2'h1, 13'h0, 0, 0, 0);
        exp_q = '{16'hB000, 16'hB001, 16'hA002, 16'hA003};
        rd_stream(RDL - 2);
        m.nop(5);
        m.put(SDI_ACT, 2'h1, 13'h0, 0, 0, 0);
        m.nop(5);
    endtask

    task automatic t_bst();
        int n0;
        n0 = n_ill;
        m.put(SDI_RD, 2'h0, 13'h0, 0, 0, 0);
        m.put(SDI_BST, 2'h2, 13'h0, 0, 0, 0);
        m.nop(1);
        `CHK(bank_state[0], BK_ACTIVE);
        m.put(SDI_PRE, 2'h0, 13'h0, 0, 0, 1'b1);
        m.put(SDI_BST, 2'h0, 13'h0, 0, 0, 0);
        m.put(SDI_REF, 2'h0, 13'h0, 0, 0, 0);
        m.nop(4);
        `CHK(n_ill, n0 + 2);
        `CHK(bank_state[1], BK_ACTIVE);
        `CHK(bank_state[0], BK_ACTIVE);
    endtask

    // Bank 0 auto-precharge burst cut by bank 1; reopen one edge too early.
    task automatic t_ap();
        logic fw;
        logic sw;
        int d;
        int n0;
        for (int i = 0; i < 4; i++) begin
            fw = i[0];
            sw = i[1];
            d = fw ? WR_CYC + RP_CYC : RP_CYC;
            n0 = n_ill;
            m.put(SDI_NOP, 2'h0, 13'h0, 0, sw & ~fw, 0);
            m.put(fw ? SDI_WR : SDI_RD, 2'h0, 13'h0408, 16'h1234,
                  sw & ~fw, 0);
            `CHK(bank_state[0], fw ? BK_WR_AP : BK_RD_AP);
            m.put(sw ? SDI_WR : SDI_RD, 2'h1, 13'h0, 0, 0, 0);
            m.nop(d - 2);
            m.put(SDI_ACT, 2'h0, 13'h0, 0, 0, 0);
            m.put(SDI_ACT, 2'h0, 13'h0, 0, 0, 0);
            `CHK(bank_state[0], BK_ACTV);
            m.nop(4);
            `CHK(n_ill, n0 + 1);
        end
    endtask

    // Second burst masks words 0, 2 and 3, so only column 13 changes.
    task automatic t_wbuf();
        logic rdy;
        int n0;
        rdy = 1'b1;
        n0 = n_ill;
        for (int i = 0; i < 4; i++) begin
            rdy = rdy & wbuf_ready;
            m.put(i == 0 ? SDI_WR : SDI_NOP, 2'h1, 13'h000C,
                  16'h9000 + 16'(i), 1'b0, 1'b0);
        end
        m.put(SDI_WR, 2'h1, 13'h000C, 16'h5555, 1'b1, 1'b0);
        m.put(SDI_NOP, 2'h0, 13'h0, 16'h6666, 1'b0, 1'b0);
        m.put(SDI_NOP, 2'h0, 13'h0, 16'h7777, 1'b1, 1'b0);
        m.put(SDI_NOP, 2'h0, 13'h0, 16'h8888, 1'b1, 1'b0);
        m.nop(1);
        `CHK(rdy, 1'b1);
        `CHK(bank_state[1], BK_ACTIVE);
        m.put(SDI_RD, 2'h1, 13'h000C, 0, 0, 0);
        exp_q = '{16'h9000, 16'h6666, 16'h9002, 16'h9003};
        rd_stream(RDL - 1);
        `CHK(n_ill, n0);
    endtask

    // Commands during the exit time are ignored up to its last edge.
    task automatic t_srf();
        int n0;
        n0 = n_ill;
        m.put(SDI_PRE, 2'h0, 13'h0400, 0, 0, 0);
        m.nop(6);
        m.cke = 1'b0;
        m.put(SDI_REF, 2'h0, 13'h0, 0, 0, 0);
        m.nop(3);
        `CHK(self_refresh, 1'b1);
        m.cke = 1'b1;
        m.nop(XSR_CYC);
        m.put(SDI_ACT, 2'h2, 13'h0, 0, 0, 0);
        `CHK({self_refresh, bank_state[2]}, BK_IDLE);
        m.put(SDI_ACT, 2'h2, 13'h0, 0, 0, 0);
        `CHK(bank_state[2], BK_ACTV);
        `CHK(n_ill, n0);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        `CHK(bank_state, '0);
        `CHK({dq_oe, illegal_cmd, self_refresh, wbuf_ready}, 4'h1);
        m.nop(2);
        t_act();
        t_write();
        t_wr_cuts_rd();
        t_pre_keeps();
        t_bst();
        t_ap();
        t_wbuf();
        t_srf();
        tally_and_finish();
    end
endmodule // test_sdi_bank_ctrl

`default_nettype wire
